// ===== shared/capture_pkg.sv
package capture_pkg;
	localparam int unsigned AW = 12;
	localparam int unsigned CW = 13;
	localparam logic [12:0] MEM_DEPTH = 13'h1000;
	localparam logic [12:0] REARM_SAMPLES = 13'h0028;
	localparam int unsigned BLOCK_SHIFT = 4;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_PRE = 8'h08;
	localparam logic [7:0] OFS_POST = 8'h0C;
	localparam logic [7:0] OFS_SEG = 8'h10;
	localparam logic [7:0] OFS_PAT_HI = 8'h14;
	localparam logic [7:0] OFS_PAT_LO = 8'h18;
	localparam logic [7:0] OFS_PAT_EDGE = 8'h1C;
	localparam logic [7:0] OFS_DIV = 8'h20;
	localparam logic [7:0] OFS_FREE = 8'h24;
	localparam logic [7:0] OFS_NOTIFY = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2C;
	localparam logic [7:0] OFS_ASYNC = 8'h30;
	localparam logic [7:0] OFS_TSTAMP = 8'h34;
	localparam logic [31:0] MODE_RESET = 32'h0001_0000;
	localparam logic [8:0] LEN_RESET = 9'h001;
	localparam logic [7:0] SEG_RESET = 8'h10;
	localparam logic [12:0] NOTIFY_RESET = 13'h0800;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PRE = 3'b001,
		ST_ARMED = 3'b010,
		ST_POST = 3'b011,
		ST_GATE = 3'b100,
		ST_REARM = 3'b101,
		ST_DONE = 3'b110
	} state_t;
	typedef enum logic [1:0] {
		MODE_RING = 2'b00,
		MODE_FIFO = 2'b01,
		MODE_MULTI = 2'b10,
		MODE_GATED = 2'b11
	} acq_mode_t;
endpackage : capture_pkg

// ===== design/logic_capture_trigger_control.sv
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
// mode register: [1:0] mode, [2] stream, [4:3] clock, [6:5] ext edge,
// [8:7] state clock edge, [9] gate level, [11:10] stamp base, [12] stamp on,
// [13] clock out on, [15:14] channels, [19:16] source enables,
// [21:20] pattern edge, [25:22] clock delay, [28:26] line 0, [31:29] line 1
module logic_capture_trigger_control
	import capture_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [31:0] sample_data_inputs,
	input wire logic external_trigger_input,
	input wire logic external_clock_input,
	input wire logic gate_input,
	input wire logic timestamp_ref_input,
	input wire logic [7:0] hub_trigger_inputs,
	output logic mem_wr_valid,
	output logic [11:0] mem_wr_addr,
	output logic [31:0] mem_wr_data,
	output logic ts_wr_valid,
	output logic [31:0] ts_wr_data,
	output logic stream_irq,
	output logic trigger_output,
	output logic sampling_clock_output,
	output logic multi_function_line_0,
	output logic multi_function_line_1
);
	typedef struct packed {
		state_t st;
		logic [31:0] mode;
		logic [8:0] pre_blk;
		logic [8:0] post_blk;
		logic [7:0] seg_blk;
		logic [31:0] pat_hi;
		logic [31:0] pat_lo;
		logic [31:0] pat_edge;
		logic [7:0] div;
		logic [12:0] notify;
		logic [1:0] async_out;
		logic [31:0] d_s1;
		logic [31:0] d_s2;
		logic [2:0] trg_s;
		logic [2:0] clk_s;
		logic [1:0] gate_s;
		logic [2:0] ref_s;
		logic [7:0] hub_s1;
		logic [7:0] hub_s2;
		logic [15:0] dly;
		logic [7:0] div_cnt;
		logic [31:0] prev;
		logic pend_ext;
		logic pend_sw;
		logic [12:0] wr_off;
		logic [12:0] seg_base;
		logic [12:0] cnt;
		logic [12:0] fill;
		logic [15:0] seg_count;
		logic overrun;
		logic trig_seen;
		logic [31:0] ts_cnt;
		logic mem_wr;
		logic [11:0] mem_addr;
		logic [31:0] mem_data;
		logic ts_wr;
		logic [31:0] ts_data;
		logic irq;
		logic trig_out;
		logic clk_out;
		logic mf0;
		logic mf1;
		logic [31:0] rdata;
	} cap_t;

	cap_t cur_r;
	cap_t cur_nxt;

	// block count to samples; a zero count still means the 16-sample minimum
	function automatic logic [12:0] blocks_to_len(input logic [8:0] blk);
		logic [8:0] b;
		b = (blk == 9'h000) ? 9'h001 : blk;
		return {b[8:0], 4'h0};
	endfunction : blocks_to_len

	// multi-function line source select
	function automatic logic line_select(input logic [2:0] sel, input logic abit,
		input logic trg, input state_t st, input logic seen);
		logic v;
		unique case (sel)
			3'h0: v = abit;
			3'h1: v = trg;
			3'h2: v = (st == ST_ARMED);
			3'h3: v = seen;
			3'h4: v = (st == ST_DONE);
			default: v = 1'b0;
		endcase
		return v;
	endfunction : line_select

	logic wr_hit;
	logic rd_hit;
	acq_mode_t amode;
	logic streaming;
	logic [12:0] seg_len;
	logic [12:0] pre_need;
	logic [12:0] post_len;
	logic [31:0] chan_mask;
	logic [31:0] cur_word;
	logic se;
	logic gate_act;
	logic pat_fire;
	logic trig_fire;
	logic do_write;
	logic wr_ok;
	logic seg_end;
	logic [12:0] next_base;
	logic [31:0] rise;
	logic [31:0] fall;
	logic edge_ok;
	logic clk_rise;
	logic clk_fall;
	logic ext_rise;
	logic ext_fall;
	logic [12:0] freed;

	// derived configuration and pin events
	always_comb
	begin
		amode = acq_mode_t'(cur_r.mode[1:0]);
		streaming = (amode == MODE_FIFO) | cur_r.mode[2];
		seg_len = ((amode == MODE_RING) || (amode == MODE_FIFO)) ? MEM_DEPTH
			: blocks_to_len({1'b0, cur_r.seg_blk});
		post_len = blocks_to_len(cur_r.post_blk);
		pre_need = (amode == MODE_RING) ? seg_len - post_len
			: blocks_to_len(cur_r.pre_blk);
		unique case (cur_r.mode[15:14])
			2'b01: chan_mask = 32'h0000_FFFF;
			2'b10: chan_mask = 32'h0000_00FF;
			default: chan_mask = 32'hFFFF_FFFF;
		endcase
		cur_word = cur_r.d_s2 & chan_mask;
		// edges of the state clock and the external trigger; narrow pulses are missed, so the source keeps min times
		clk_rise = cur_r.clk_s[1] & ~cur_r.clk_s[2];
		clk_fall = ~cur_r.clk_s[1] & cur_r.clk_s[2];
		ext_rise = cur_r.trg_s[1] & ~cur_r.trg_s[2];
		ext_fall = ~cur_r.trg_s[1] & cur_r.trg_s[2];
		if (cur_r.mode[4:3] == 2'b10)
			se = cur_r.dly[cur_r.mode[25:22]];
		else
			se = (cur_r.div_cnt == 8'h00);
		gate_act = (cur_r.gate_s[1] == cur_r.mode[9]);
		rise = cur_word & ~cur_r.prev & cur_r.pat_edge;
		fall = ~cur_word & cur_r.prev & cur_r.pat_edge;
		unique case (cur_r.mode[21:20])
			2'b01: edge_ok = |fall;
			2'b10: edge_ok = |(rise | fall);
			default: edge_ok = |rise;
		endcase
		pat_fire = ((cur_word & cur_r.pat_hi) == cur_r.pat_hi)
			&& ((~cur_word & cur_r.pat_lo) == cur_r.pat_lo)
			&& ((cur_r.pat_edge == 32'h0000_0000) || edge_ok);
		trig_fire = se & ((cur_r.mode[16] & cur_r.pend_ext)
			| (cur_r.mode[17] & pat_fire)
			| (cur_r.mode[18] & cur_r.pend_sw)
			| (cur_r.mode[19] & (|cur_r.hub_s2)));
		wr_ok = ~(streaming && (cur_r.fill == MEM_DEPTH));
		do_write = se && ((cur_r.st == ST_PRE) || (cur_r.st == ST_ARMED)
			|| (cur_r.st == ST_POST) || (cur_r.st == ST_GATE));
		next_base = cur_r.seg_base + seg_len;
		seg_end = (cur_r.st == ST_POST) && se && (cur_r.cnt + 13'h0001 >= post_len);
		wr_hit = reg_wr;
		rd_hit = reg_rd;
		freed = (wr_hit && (reg_addr == OFS_FREE)) ? reg_wdata[12:0] : 13'h0000;
	end

	// next state of the whole block
	always_comb
	begin
		cur_nxt = cur_r;
		cur_nxt.d_s1 = sample_data_inputs;
		cur_nxt.d_s2 = cur_r.d_s1;
		cur_nxt.trg_s = {cur_r.trg_s[1:0], external_trigger_input};
		cur_nxt.clk_s = {cur_r.clk_s[1:0], external_clock_input};
		cur_nxt.gate_s = {cur_r.gate_s[0], gate_input};
		cur_nxt.ref_s = {cur_r.ref_s[1:0], timestamp_ref_input};
		cur_nxt.hub_s1 = hub_trigger_inputs;
		cur_nxt.hub_s2 = cur_r.hub_s1;
		cur_nxt.mem_wr = 1'b0;
		cur_nxt.ts_wr = 1'b0;
		cur_nxt.trig_out = 1'b0;
		cur_nxt.dly = {cur_r.dly[14:0],
			(cur_r.mode[7] & clk_rise) | (cur_r.mode[8] & clk_fall)};
		cur_nxt.div_cnt = (cur_r.div_cnt >= cur_r.div) ? 8'h00
			: cur_r.div_cnt + 8'h01;
		// pending triggers: a new event wins over consumption in the same cycle
		cur_nxt.pend_ext = (cur_r.pend_ext & ~se)
			| (cur_r.mode[5] & ext_rise) | (cur_r.mode[6] & ext_fall);
		cur_nxt.pend_sw = (cur_r.pend_sw & ~se)
			| (wr_hit && (reg_addr == OFS_CTRL) && reg_wdata[2]);
		if (se)
		begin
			cur_nxt.prev = cur_word;
			cur_nxt.ts_cnt = cur_r.ts_cnt + 32'h0000_0001;
			if (cur_r.mode[13])
				cur_nxt.clk_out = ~cur_r.clk_out;
		end
		if (!cur_r.mode[13])
			cur_nxt.clk_out = 1'b0;
		// time base restarts from the selected zero
		if ((cur_r.mode[11:10] == 2'b10) && cur_r.ref_s[1] && !cur_r.ref_s[2])
			cur_nxt.ts_cnt = 32'h0000_0000;
		if (wr_hit && (reg_addr == OFS_CTRL) && reg_wdata[3]
			&& (cur_r.mode[11:10] == 2'b01))
			cur_nxt.ts_cnt = 32'h0000_0000;

		// sample store; in streaming a full buffer drops the sample and flags it
		if (do_write)
		begin
			if (wr_ok)
			begin
				cur_nxt.mem_wr = 1'b1;
				cur_nxt.mem_addr = cur_r.seg_base[11:0] + cur_r.wr_off[11:0];
				cur_nxt.mem_data = cur_word;
				cur_nxt.wr_off = (cur_r.wr_off + 13'h0001 >= seg_len) ? 13'h0000
					: cur_r.wr_off + 13'h0001;
			end
			else
				cur_nxt.overrun = 1'b1;
		end
		cur_nxt.fill = cur_r.fill + {12'h000, streaming & do_write & wr_ok}
			- ((freed > cur_r.fill) ? cur_r.fill : freed);
		cur_nxt.irq = streaming && (cur_r.fill >= cur_r.notify);

		// acquisition sequence
		unique case (cur_r.st)
			ST_IDLE, ST_DONE:
			begin
			end
			ST_PRE:
				if (se)
				begin
					cur_nxt.cnt = cur_r.cnt + 13'h0001;
					if (cur_r.cnt + 13'h0001 >= pre_need)
						cur_nxt.st = ST_ARMED;
				end
			ST_ARMED:
				if (amode == MODE_GATED)
				begin
					if (se && gate_act)
						cur_nxt.st = ST_GATE;
				end
				else if (trig_fire && (amode != MODE_FIFO))
				begin
					cur_nxt.st = ST_POST;
					cur_nxt.cnt = 13'h0000;
				end
			ST_GATE:
				if (se && !gate_act)
				begin
					cur_nxt.st = ST_POST;
					cur_nxt.cnt = 13'h0000;
				end
			ST_POST:
				if (se)
					cur_nxt.cnt = cur_r.cnt + 13'h0001;
			ST_REARM:
				if (se)
				begin
					cur_nxt.cnt = cur_r.cnt + 13'h0001;
					if (cur_r.cnt + 13'h0001 >= REARM_SAMPLES)
					begin
						cur_nxt.st = ST_PRE;
						cur_nxt.cnt = 13'h0000;
					end
				end
			default:
				cur_nxt.st = ST_IDLE;
		endcase

		// end of a post area: ring stops, segmented modes move on and re-arm, or stop when memory is full and stream is off
		if (seg_end)
		begin
			cur_nxt.cnt = 13'h0000;
			if (amode == MODE_RING)
				cur_nxt.st = ST_DONE;
			else
			begin
				cur_nxt.seg_count = cur_r.seg_count + 16'h0001;
				cur_nxt.wr_off = 13'h0000;
				cur_nxt.st = ST_REARM;
				if (next_base + seg_len > MEM_DEPTH)
				begin
					if (cur_r.mode[2])
						cur_nxt.seg_base = 13'h0000;
					else
						cur_nxt.st = ST_DONE;
				end
				else
					cur_nxt.seg_base = next_base;
			end
		end

		// with stamp on (mode bit 12), every trigger and gate start is logged with its time position
		if (trig_fire && (cur_r.st == ST_ARMED))
		begin
			cur_nxt.trig_out = 1'b1;
			cur_nxt.trig_seen = 1'b1;
			if (cur_r.mode[12])
			begin
				cur_nxt.ts_wr = 1'b1;
				cur_nxt.ts_data = cur_r.ts_cnt;
			end
		end
		if ((amode == MODE_GATED) && se && gate_act && (cur_r.st == ST_ARMED))
		begin
			cur_nxt.trig_seen = 1'b1;
			cur_nxt.ts_wr = cur_r.mode[12];
			cur_nxt.ts_data = cur_r.ts_cnt;
		end

		// register writes
		if (wr_hit)
		begin
			unique case (reg_addr)
				OFS_CTRL:
				begin
					if (reg_wdata[0])
					begin
						cur_nxt.st = ST_PRE;
						cur_nxt.cnt = 13'h0000;
						cur_nxt.wr_off = 13'h0000;
						cur_nxt.seg_base = 13'h0000;
						cur_nxt.seg_count = 16'h0000;
						cur_nxt.fill = 13'h0000;
						cur_nxt.overrun = 1'b0;
						cur_nxt.trig_seen = 1'b0;
						if (cur_r.mode[11:10] == 2'b00)
							cur_nxt.ts_cnt = 32'h0000_0000;
					end
					if (reg_wdata[1])
						cur_nxt.st = ST_IDLE;
				end
				OFS_MODE: cur_nxt.mode = reg_wdata;
				OFS_PRE: cur_nxt.pre_blk = reg_wdata[8:0];
				OFS_POST: cur_nxt.post_blk = reg_wdata[8:0];
				OFS_SEG: cur_nxt.seg_blk = reg_wdata[7:0];
				OFS_PAT_HI: cur_nxt.pat_hi = reg_wdata;
				OFS_PAT_LO: cur_nxt.pat_lo = reg_wdata;
				OFS_PAT_EDGE: cur_nxt.pat_edge = reg_wdata;
				OFS_DIV: cur_nxt.div = reg_wdata[7:0];
				OFS_NOTIFY: cur_nxt.notify = reg_wdata[12:0];
				OFS_ASYNC: cur_nxt.async_out = reg_wdata[1:0];
				default:
				begin
				end
			endcase
		end

		// read data stands only in the cycle after the strobe
		cur_nxt.rdata = 32'h0000_0000;
		if (rd_hit)
		begin
			unique case (reg_addr)
				OFS_MODE: cur_nxt.rdata = cur_r.mode;
				OFS_PRE: cur_nxt.rdata = {23'h000000, cur_r.pre_blk};
				OFS_POST: cur_nxt.rdata = {23'h000000, cur_r.post_blk};
				OFS_SEG: cur_nxt.rdata = {24'h000000, cur_r.seg_blk};
				OFS_PAT_HI: cur_nxt.rdata = cur_r.pat_hi;
				OFS_PAT_LO: cur_nxt.rdata = cur_r.pat_lo;
				OFS_PAT_EDGE: cur_nxt.rdata = cur_r.pat_edge;
				OFS_DIV: cur_nxt.rdata = {24'h000000, cur_r.div};
				OFS_FREE: cur_nxt.rdata = {19'h00000, cur_r.fill};
				OFS_NOTIFY: cur_nxt.rdata = {19'h00000, cur_r.notify};
				OFS_STATUS: cur_nxt.rdata = {cur_r.seg_count, 11'h000,
					cur_r.overrun, cur_r.trig_seen, cur_r.st};
				OFS_ASYNC: cur_nxt.rdata = {30'h00000000, cur_r.async_out};
				OFS_TSTAMP: cur_nxt.rdata = cur_r.ts_cnt;
				default: cur_nxt.rdata = 32'h0000_0000;
			endcase
		end

		cur_nxt.mf0 = line_select(cur_r.mode[28:26], cur_r.async_out[0],
			cur_r.trig_out, cur_r.st, cur_r.trig_seen);
		cur_nxt.mf1 = line_select(cur_r.mode[31:29], cur_r.async_out[1],
			cur_r.trig_out, cur_r.st, cur_r.trig_seen);
	end

	// single state register; configuration takes its reset values
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cur_r <= '0;
			cur_r.st <= ST_IDLE;
			cur_r.mode <= MODE_RESET;
			cur_r.pre_blk <= LEN_RESET;
			cur_r.post_blk <= LEN_RESET;
			cur_r.seg_blk <= SEG_RESET;
			cur_r.notify <= NOTIFY_RESET;
		end
		else
			cur_r <= cur_nxt;
	end

	assign reg_rdata = cur_r.rdata;
	assign mem_wr_valid = cur_r.mem_wr;
	assign mem_wr_addr = cur_r.mem_addr;
	assign mem_wr_data = cur_r.mem_data;
	assign ts_wr_valid = cur_r.ts_wr;
	assign ts_wr_data = cur_r.ts_data;
	assign stream_irq = cur_r.irq;
	assign trigger_output = cur_r.trig_out;
	assign sampling_clock_output = cur_r.clk_out;
	assign multi_function_line_0 = cur_r.mf0;
	assign multi_function_line_1 = cur_r.mf1;
endmodule : logic_capture_trigger_control

// ===== testbench/capture_sva.sv
`timescale 1ns/100ps
module capture_sva
	import capture_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic mem_wr_valid,
	input wire logic [11:0] mem_wr_addr,
	input wire logic ts_wr_valid,
	input wire logic trigger_output,
	input wire logic sampling_clock_output
);
	logic [31:0] mode_r;
	logic [8:0] post_r;
	logic [12:0] cnt_r;
	logic seen_r;
	logic start;
	logic rm;
	logic [12:0] post_n;
	// block 0 still means 16 samples
	assign post_n = (post_r == 9'h000) ? 13'h0010 : {post_r, 4'h0};
	assign start = reg_wr && reg_addr == OFS_CTRL && reg_wdata[0];
	// ring and multiple recording share an even mode code
	assign rm = !mode_r[0];
	// settings shadowed from the write port, plus samples since start or trigger
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_r <= MODE_RESET;
			post_r <= LEN_RESET;
			cnt_r <= 13'h0000;
			seen_r <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == OFS_MODE)
				mode_r <= reg_wdata;
			if (reg_wr && reg_addr == OFS_POST)
				post_r <= reg_wdata[8:0];
			if (start || trigger_output)
				cnt_r <= 13'h0000;
			else if (mem_wr_valid && cnt_r != 13'h1FFF)
				cnt_r <= cnt_r + 13'h0001;
			if (start)
				seen_r <= 1'b0;
			else if (trigger_output)
				seen_r <= 1'b1;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	chk_rdata_slot: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
		else $error("read data outside its slot");
	chk_unmapped_zero: assert property (
		$past(reg_rd) && $past(reg_addr) > OFS_TSTAMP |-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_sampling_clock_output_off: assert property (
		!mode_r[13] && !$past(mode_r[13]) |-> !sampling_clock_output)
		else $error("sampling clock driven while off");
	chk_trig_spacing: assert property (
		trigger_output && rm |=> !trigger_output [*8])
		else $error("triggers too close");
	chk_trig_after_pre: assert property (
		trigger_output && mode_r[1:0] == MODE_RING |-> cnt_r >= MEM_DEPTH - post_n)
		else $error("trigger taken before pre count");
	chk_post_count: assert property (
		mem_wr_valid && seen_r && mode_r[1:0] == MODE_RING |-> cnt_r < post_n)
		else $error("too many samples after trigger");
	chk_stamp_follows: assert property (
		trigger_output && rm && mode_r[12] |-> ##[0:2] ts_wr_valid)
		else $error("trigger not stamped");
	chk_ring_addr: assert property (
		mode_r[1:0] == MODE_RING && mem_wr_valid && $past(mem_wr_valid)
		|-> mem_wr_addr == $past(mem_wr_addr) + 12'h001)
		else $error("ring address not consecutive");
endmodule : capture_sva

bind logic_capture_trigger_control capture_sva chk (.sys_clk, .rst_b, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_wr_valid, .mem_wr_addr,
	.ts_wr_valid, .trigger_output, .sampling_clock_output);

// ===== testbench/signal_source.sv
`timescale 1ns/100ps
// probed target: data pins, trigger line and a gapped state clock
module signal_source (
	output logic [31:0] sample_data_inputs = 32'h0000_0000,
	output logic external_trigger_input = 1'b0,
	output logic external_clock_input = 1'b0
);
	// pattern steps once per block cycle on the falling edge, so each sample sees a new word
	always #10 sample_data_inputs <= sample_data_inputs + 32'h0000_0001;
	// a level change, called right after a clock edge; held long enough to be synced
	task automatic flip_trigger();
		external_trigger_input <= !external_trigger_input;
	endtask : flip_trigger
	// n periods of 160 ns started on a clock edge, then the line rests low
	task automatic clock_burst(input int n);
		repeat (n)
		begin
			#80 external_clock_input <= 1'b1;
			#80 external_clock_input <= 1'b0;
		end
	endtask : clock_burst
endmodule : signal_source

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench
	import capture_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_b;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [31:0] sample_data_inputs;
	logic external_trigger_input;
	logic external_clock_input;
	logic gate_input;
	logic timestamp_ref_input;
	logic [7:0] hub_trigger_inputs;
	logic mem_wr_valid;
	logic [11:0] mem_wr_addr;
	logic ts_wr_valid;
	logic trigger_output;
	logic sampling_clock_output;
	logic [31:0] mem_wr_data;
	logic [31:0] ts_wr_data;
	logic stream_irq;
	logic multi_function_line_0;
	logic multi_function_line_1;
	logic [31:0] trg_data;
	logic [31:0] ts_last;
	logic [31:0] ts_prev;
	int n_mf = 0;
	logic [11:0] last_addr;
	logic [3:0] slot;
	int err_total = 0;
	int tests_run = 0;
	int n_wr = 0, n_trg = 0, n_ts = 0, n_clk = 0, at_trg = 0, idle = 0, idle_last = 0;
	logic_capture_trigger_control DUT (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .sample_data_inputs, .external_trigger_input,
		.external_clock_input, .gate_input, .timestamp_ref_input, .hub_trigger_inputs,
		.mem_wr_valid, .mem_wr_addr, .mem_wr_data, .ts_wr_valid, .ts_wr_data,
		.stream_irq, .trigger_output, .sampling_clock_output,
		.multi_function_line_0, .multi_function_line_1);
	signal_source src (.sample_data_inputs, .external_trigger_input,
		.external_clock_input);
	always #5 sys_clk = ~sys_clk;
	// tallies of what the block hands out, taken before its own updates land
	always @(posedge sys_clk)
	begin
		if (mem_wr_valid === 1'b1)
		begin
			n_wr <= n_wr + 1;
			last_addr <= mem_wr_addr;
		end
		if (trigger_output === 1'b1)
		begin
			n_trg <= n_trg + 1;
			at_trg <= n_wr + (mem_wr_valid === 1'b1);
			slot <= last_addr[11:8];
			idle_last <= idle;
			idle <= 0;
			trg_data <= mem_wr_data;
		end
		else if (mem_wr_valid !== 1'b1)
			idle <= idle + 1;
		if (ts_wr_valid === 1'b1)
		begin
			ts_prev <= ts_last;
			ts_last <= ts_wr_data;
		end
		n_mf <= n_mf + (multi_function_line_0 === 1'b1);
		n_ts <= n_ts + (ts_wr_valid === 1'b1);
		n_clk <= n_clk + (sampling_clock_output === 1'b1);
	end
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// idle cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd_cmp(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] v;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge sys_clk);
		cmp(what, exp, v & m);
	endtask : rd_cmp
	task automatic reg_defaults();
		rd_cmp("mode", OFS_MODE, 32'hFFFF_FFFF, MODE_RESET);
		rd_cmp("pre", OFS_PRE, 32'hFFFF_FFFF, 32'(LEN_RESET));
		rd_cmp("seg", OFS_SEG, 32'hFFFF_FFFF, 32'(SEG_RESET));
		rd_cmp("notify", OFS_NOTIFY, 32'hFFFF_FFFF, 32'(NOTIFY_RESET));
		rd_cmp("status", OFS_STATUS, 32'h0000_0007, 32'(ST_IDLE));
		rd_cmp("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask : reg_defaults
	// an edge during the pre fill must not end the run early
	task automatic ring_run();
		int w0;
		int t0;
		wr(OFS_POST, 32'h0000_0002);
		wr(OFS_MODE, 32'h0001_2060);
		w0 = n_wr;
		t0 = n_trg;
		wr(OFS_CTRL, 32'h0000_0001);
		src.flip_trigger();
		tick(4400);
		src.flip_trigger();
		tick(300);
		cmp("ring triggers", 32'h0000_0001, n_trg - t0);
		cmp("pre filled", 32'h0000_0001, (at_trg - w0) > 4064);
		cmp("post samples", 32'h0000_0020, n_wr - at_trg);
		rd_cmp("ring state", OFS_STATUS, 32'h0000_0007, 32'(ST_DONE));
		cmp("clock out ran", 32'h0000_0001, n_clk > 0);
	endtask : ring_run
	// three triggers, no restart, each segment in its own 256-word slot
	task automatic multi_run();
		int t0;
		int s0;
		wr(OFS_PRE, 32'h0000_0000);
		wr(OFS_POST, 32'h0000_0001);
		wr(OFS_SEG, 32'h0000_0010);
		wr(OFS_MODE, 32'h0001_1062);
		t0 = n_trg;
		s0 = n_ts;
		wr(OFS_CTRL, 32'h0000_0001);
		repeat (3)
		begin
			tick(150);
			src.flip_trigger();
		end
		tick(150);
		cmp("segments", 32'h0000_0003, n_trg - t0);
		cmp("stamps", 32'h0000_0003, n_ts - s0);
		cmp("third slot", 32'h0000_0002, slot);
		cmp("rearm idle", 32'h0000_0001, idle_last >= 40);
		wr(OFS_CTRL, 32'h0000_0002);
	endtask : multi_run
	// samples follow the delayed state clock and stop in its gaps
	task automatic state_run();
		int w0;
		int w1;
		wr(OFS_MODE, 32'h00C0_0190);
		wr(OFS_CTRL, 32'h0000_0001);
		w0 = n_wr;
		src.clock_burst(8);
		tick(30);
		w1 = n_wr;
		tick(300);
		cmp("gap quiet", w1, n_wr);
		cmp("burst taken", 32'h0000_0001, (w1 - w0 >= 8) && (w1 - w0 <= 16));
		wr(OFS_CTRL, 32'h0000_0002);
	endtask : state_run
	// pattern on the low byte of the 8-channel counter; stamped and shown on line 0
	task automatic pattern_run();
		int t0;
		int m0;
		wr(OFS_ASYNC, 32'h0000_0002);
		tick(1);
		cmp("async line", 32'h0000_0001, multi_function_line_1);
		wr(OFS_PAT_HI, 32'h0000_00A5);
		wr(OFS_PAT_LO, 32'h0000_005A);
		wr(OFS_MODE, 32'h0402_9002);
		t0 = n_trg;
		m0 = n_mf;
		wr(OFS_CTRL, 32'h0000_0001);
		tick(600);
		wr(OFS_CTRL, 32'h0000_0002);
		tick(4);
		cmp("pattern fired", 32'h0000_0001, (n_trg - t0) >= 2);
		cmp("masked word", 32'h0000_00A5, trg_data);
		cmp("stamp step", 32'h0000_0100, ts_last - ts_prev);
		cmp("line 0 pulses", n_trg - t0, n_mf - m0);
	endtask : pattern_run
	// streaming fill raises the host request; freeing the space drops it again
	task automatic stream_run();
		wr(OFS_NOTIFY, 32'h0000_0020);
		wr(OFS_MODE, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_0001);
		tick(60);
		cmp("irq raised", 32'h0000_0001, stream_irq);
		wr(OFS_CTRL, 32'h0000_0002);
		wr(OFS_FREE, 32'h0000_1000);
		tick(2);
		cmp("irq dropped", 32'h0000_0000, stream_irq);
	endtask : stream_run
	// one hub line held 60 cycles: one trigger, re-arming outlasts the rest of the pulse
	task automatic hub_run();
		int t0;
		wr(OFS_MODE, 32'h0008_0002);
		t0 = n_trg;
		wr(OFS_CTRL, 32'h0000_0001);
		tick(40);
		hub_trigger_inputs <= 8'h40;
		tick(60);
		hub_trigger_inputs <= 8'h00;
		tick(100);
		cmp("hub trigger", 32'h0000_0001, n_trg - t0);
		wr(OFS_CTRL, 32'h0000_0002);
	endtask : hub_run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		gate_input = 1'b0;
		timestamp_ref_input = 1'b0;
		hub_trigger_inputs = 8'h00;
		tick(16);
		rst_b <= 1'b1;
		reg_defaults();
		ring_run();
		multi_run();
		state_run();
		pattern_run();
		stream_run();
		hub_run();
		tally_and_finish();
	end
	// hang guard, well past the roughly 70 us the tests need
	initial
	begin
		#200000;
		err_total++;
		tally_and_finish();
	end
endmodule : testbench
